// File: edge_latch_cfg.svh
// Constants for the rising edge input latch.
`ifndef EDGE_LATCH_CFG_SVH
`define EDGE_LATCH_CFG_SVH
`define NARROW_INPUTS   14
`define WIDE_INPUTS     21
`define NARROW_MAX      32'h0000_3FFF
`define WIDE_MAX        32'h001F_FFFF
`define LATCH_RESET     21'h00_0000
`define INDEX_WIDTH     5
`endif

// File: edge_latch_pkg.sv
// Types for the rising edge input latch.
package edge_latch_pkg;
    typedef enum logic [1:0] {
        ACC_BIT  = 2'h1,
        ACC_WORD = 2'h2
    } access_scope_t;
endpackage

// File: rising_edge_input_latch.sv
// Rising edge input latch with bitwise and whole-word command access.
// Notes on behaviour
// [RQ1] A low to high input change sets its bit until cleared.
// [RQ2] Single-bit read returns one bit: edge seen since last read.
// [RQ3] Word read returns all bits, input 1 at bit zero.
// [RQ4] Reading an input's bit clears that latch afterwards.
// [RQ5] Writing zero clears a latch, writing one leaves it unchanged.
// [RQ6] Width is 14 or 21 inputs, word values up to 3FFF or 1FFFFF.
// [RQ7] Inputs synchronised, latches clear at reset, new edge beats a clear.
`timescale 1ns/1ps
`include "edge_latch_cfg.svh"

module rising_edge_input_latch
    import edge_latch_pkg::*;
#(
    parameter int INPUTS = `WIDE_INPUTS
) (
    // Clock and reset.
    input  wire logic                      mclk,
    input  wire logic                      rst_n,
    // Field inputs.
    input  wire logic [INPUTS-1:0]         field_in,
    // Command port.
    input  wire logic                      cmd_valid,
    input  wire logic                      cmd_write,
    input  wire access_scope_t             cmd_scope,
    input  wire logic [`INDEX_WIDTH-1:0]   cmd_index,
    input  wire logic [INPUTS-1:0]         cmd_wdata,
    // Read answer.
    output logic                           rsp_valid,
    output logic [INPUTS-1:0]              rsp_data
);

    logic               rst_s1_q;
    logic               rst_s2_q;
    logic [INPUTS-1:0]  sync1_q;
    logic [INPUTS-1:0]  sync2_q;
    logic [INPUTS-1:0]  prev_q;
    logic [INPUTS-1:0]  rising_edge_latch_q;
    logic [INPUTS-1:0]  rising_edge_latch_d;
    logic               rsp_valid_q;
    logic [INPUTS-1:0]  rsp_data_q;

    wire                rst_int_n = rst_s2_q;
    wire [INPUTS-1:0]   edges;
    wire                index_ok;
    wire                word_acc;
    wire                bit_acc;
    wire [INPUTS-1:0]   bit_sel;
    wire [INPUTS-1:0]   clear_mask;
    wire                do_read;
    wire                do_write;
    wire [INPUTS-1:0]   read_word;

    // One-hot select of input number 1..INPUTS, zero when out of range.
    function automatic logic [INPUTS-1:0] onehot(input logic [`INDEX_WIDTH-1:0] idx);
        logic [INPUTS-1:0] r;
        r = '0;
        for (int i = 0; i < INPUTS; i++) begin
            if (idx == (`INDEX_WIDTH)'(i + 1)) begin
                r[i] = 1'b1;
            end
        end
        return r;
    endfunction

    assign bit_sel  = onehot(cmd_index);
    assign index_ok = |bit_sel;
    assign word_acc = cmd_scope == ACC_WORD;
    assign bit_acc  = cmd_scope == ACC_BIT && index_ok;
    assign do_read  = cmd_valid && !cmd_write && (word_acc || bit_acc);
    assign do_write = cmd_valid && cmd_write && (word_acc || bit_acc);
    // [RQ7] Edge on synchronised samples.
    assign edges    = sync2_q & ~prev_q;

    // [RQ4] Read clears returned bits.
    // [RQ5] Zero bits clear.
    assign clear_mask =
        do_read  ? ((cmd_scope == ACC_WORD) ? {INPUTS{1'b1}} : bit_sel) :
        do_write ? ((cmd_scope == ACC_WORD) ? ~cmd_wdata :
                    (cmd_wdata[0] ? '0 : bit_sel)) : '0;

    // [RQ2] Single bit returned in bit zero.
    // [RQ3] Whole word, input 1 at LSB.
    assign read_word = (cmd_scope == ACC_WORD) ? rising_edge_latch_q :
        {{(INPUTS-1){1'b0}}, |(rising_edge_latch_q & bit_sel)};

    // [RQ1] Sticky set, set beats clear.
    assign rising_edge_latch_d = (rising_edge_latch_q & ~clear_mask) | edges;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    // [RQ7] Two-stage input synchroniser.
    always_ff @(posedge mclk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q  <= '0;
        end else begin
            sync1_q <= field_in;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    // [RQ7] Latches clear at reset.
    always_ff @(posedge mclk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            rising_edge_latch_q <= INPUTS'(`LATCH_RESET);
            rsp_valid_q         <= 1'b0;
            rsp_data_q          <= '0;
        end else begin
            rising_edge_latch_q <= rising_edge_latch_d;
            rsp_valid_q         <= do_read;
            if (do_read) begin
                rsp_data_q <= read_word;
            end
        end
    end

    assign rsp_valid = rsp_valid_q;
    assign rsp_data  = rsp_data_q;

    // [RQ6] Width is one of the two documented variants.
    initial begin
        assert (INPUTS == `NARROW_INPUTS || INPUTS == `WIDE_INPUTS)
            else $error("Input count must be 14 or 21.");
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_int_n);

    // Checks on the latches and the answer port.
    edge_sets_bit_a: assert property ( // [RQ1]
        |edges
        |=> ((rising_edge_latch_q & $past(edges))
            == $past(edges)))
        else $error("Rising edge did not set its latch.");

    sticky_hold_a: assert property ( // [RQ1]
        clear_mask == '0
        |=> ((rising_edge_latch_q & $past(rising_edge_latch_q))
            == $past(rising_edge_latch_q)))
        else $error("Latch bit dropped without a clear.");

    bit_read_a: assert property ( // [RQ2]
        do_read && cmd_scope == ACC_BIT
        |=> rsp_valid && rsp_data[INPUTS-1:1] == '0
            && rsp_data[0] == |($past(rising_edge_latch_q) & $past(bit_sel)))
        else $error("Single bit read returned wrong value.");

    answer_pulse_a: assert property ( // [RQ2]
        rsp_valid
        |-> $past(cmd_valid)
            && !$past(cmd_write))
        else $error("Answer given without a read command.");

    word_read_a: assert property ( // [RQ3]
        do_read && cmd_scope == ACC_WORD
        |=> rsp_valid
            && rsp_data == $past(rising_edge_latch_q))
        else $error("Word read returned wrong value.");

    read_clears_a: assert property ( // [RQ4]
        do_read && cmd_scope == ACC_WORD && edges == '0
        |=> rising_edge_latch_q == '0)
        else $error("Word read did not clear latches.");

    bit_read_clr_a: assert property ( // [RQ4]
        do_read && cmd_scope == ACC_BIT
        |=> (rising_edge_latch_q & $past(bit_sel))
            == ($past(edges) & $past(bit_sel)))
        else $error("Bit read did not clear its latch.");

    write_zero_a: assert property ( // [RQ5]
        do_write && cmd_scope == ACC_WORD
        |=> rising_edge_latch_q
            == (($past(rising_edge_latch_q) & $past(cmd_wdata)) | $past(edges)))
        else $error("Word write did not mask latches.");

    bit_clear_a: assert property ( // [RQ5]
        do_write && cmd_scope == ACC_BIT && !cmd_wdata[0]
        |=> (rising_edge_latch_q & $past(bit_sel))
            == ($past(edges) & $past(bit_sel)))
        else $error("Bit write of zero did not clear its latch.");

    bit_keep_a: assert property ( // [RQ5]
        do_write && cmd_scope == ACC_BIT && cmd_wdata[0]
        |=> rising_edge_latch_q
            == ($past(rising_edge_latch_q) | $past(edges)))
        else $error("Bit write of one changed a latch.");

    width_ok_a: assert property ( // [RQ6]
        cmd_valid && cmd_scope == ACC_BIT && !index_ok
        |=> !rsp_valid
            && rising_edge_latch_q == ($past(rising_edge_latch_q) | $past(edges)))
        else $error("Command beyond the input count took effect.");

    edge_delay_a: assert property ( // [RQ7]
        $rose(sync2_q[0])
        |=> rising_edge_latch_q[0])
        else $error("Synchronised edge not latched.");

    set_wins_a: assert property ( // [RQ7]
        do_read && |edges
        |=> ((rising_edge_latch_q & $past(edges))
            == $past(edges)))
        else $error("Clear overrode a new edge.");

    word_read_c: cover property (do_read && cmd_scope == ACC_WORD && rising_edge_latch_q != '0);
    bit_write_c: cover property (do_write && cmd_scope == ACC_BIT && !cmd_wdata[0]);
    collide_c:   cover property (do_read && |(edges & clear_mask));
    bit_read_c:  cover property (bit_acc && do_read && |(rising_edge_latch_q & bit_sel));
    word_write_c: cover property (do_write && word_acc && |(rising_edge_latch_q & ~cmd_wdata));

endmodule

// File: field_source.sv
// Field device model that turns request pulses into input levels.
`timescale 1ns/1ps
module field_source (
    // Clock and requests.
    input  wire logic        mclk,
    input  wire logic [20:0] rise_req,
    // Field levels.
    output logic [20:0]      field_q
);
    logic [20:0] s1_q;
    logic [20:0] s2_q;
    always_ff @(posedge mclk) begin
        s1_q <= rise_req;
        s2_q <= s1_q;
    end
    // Each request holds the line high for two cycles.
    assign field_q = s1_q | s2_q;
endmodule

// File: rising_edge_input_latch_bench.sv
// Testbench for the rising edge input latch.
`timescale 1ns/1ps
module rising_edge_input_latch_bench;
    import edge_latch_pkg::*;
    typedef struct {logic [20:0] m; access_scope_t s; logic [4:0] i; logic [20:0] e;} row_t;
    logic mclk = 0, rst_n = 0, cmd_valid = 0, cmd_write = 0, rsp_valid;
    access_scope_t cmd_scope = ACC_WORD;
    logic [4:0] cmd_index = 5'h00;
    logic [20:0] cmd_wdata = 21'h0, rise_req = 21'h0, field_in, rsp_data;
    int bad_count = 0, checks = 0;
    row_t rows[5] = '{'{21'h1, ACC_WORD, 5'h0, 21'h1}, '{21'h0, ACC_WORD, 5'h0, 21'h0},
        '{21'h10_0000, ACC_BIT, 5'h15, 21'h1}, '{21'h0, ACC_BIT, 5'h15, 21'h0},
        '{21'h1F_FFFF, ACC_WORD, 5'h0, 21'h1F_FFFF}};
    always #25 mclk = ~mclk;
    field_source fs_u (.mclk(mclk), .rise_req(rise_req), .field_q(field_in));
    rising_edge_input_latch #(.INPUTS(21)) dut_u (.mclk(mclk), .rst_n(rst_n),
        .field_in(field_in), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_scope(cmd_scope), .cmd_index(cmd_index), .cmd_wdata(cmd_wdata),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data));
    task automatic cmp(input logic [20:0] g, input logic [20:0] e);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic go(input logic w, input access_scope_t s, input logic [4:0] i,
                      input logic [20:0] d);
        @(posedge mclk);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_scope <= s;
        cmd_index <= i;
        cmd_wdata <= d;
        @(posedge mclk);
        cmd_valid <= 1'b0;
    endtask
    task automatic rd(input access_scope_t s, input logic [4:0] i, input logic [20:0] e);
        go(1'b0, s, i, 21'h0);
        #1;
        cmp({20'h0_0000, rsp_valid}, 21'h1);
        cmp(rsp_data, e);
    endtask
    task automatic pulse(input logic [20:0] m);
        @(posedge mclk);
        rise_req <= m;
        @(posedge mclk);
        rise_req <= 21'h0;
        repeat (6) @(posedge mclk);
    endtask
    task automatic report_and_stop;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        cmp(rsp_data, 21'h0);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        foreach (rows[k]) begin
            pulse(rows[k].m);
            rd(rows[k].s, rows[k].i, rows[k].e);
        end
        pulse(21'h1F);
        go(1'b1, ACC_WORD, 5'h0, 21'h1A);
        rd(ACC_WORD, 5'h0, 21'h1A);
        pulse(21'h3);
        go(1'b1, ACC_BIT, 5'h1, 21'h0);
        go(1'b1, ACC_BIT, 5'h2, 21'h1);
        rd(ACC_WORD, 5'h0, 21'h2);
        go(1'b0, ACC_BIT, 5'h16, 21'h0);
        #1;
        cmp({20'h0_0000, rsp_valid}, 21'h0);
        @(posedge mclk);
        rise_req <= 21'h4;
        @(posedge mclk);
        rise_req <= 21'h0;
        @(posedge mclk);
        go(1'b0, ACC_WORD, 5'h0, 21'h0);
        #1;
        cmp(rsp_data, 21'h0);
        rd(ACC_WORD, 5'h0, 21'h4);
        pulse(21'h8);
        rst_n <= 1'b0;
        @(posedge mclk);
        #1;
        cmp(rsp_data, 21'h0);
        @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        rd(ACC_WORD, 5'h0, 21'h0);
        report_and_stop();
    end
endmodule
